/* File: common/slfa_defs.svh */
// Constants for the self-programming lock, fuse and signature access logic.
// Assumes one 250 MHz system clock shared by the core and the access logic.
`ifndef SLFA_DEFS_SVH
`define SLFA_DEFS_SVH

// Control register field positions
`define SLFA_BIT_ENABLE 0
`define SLFA_BIT_LOCKSEL 3
`define SLFA_BIT_SIGSEL 5
`define SLFA_BIT_BUSY 6
`define SLFA_BIT_IRQEN 7
// Command codes, bit 7 ignored
`define SLFA_CMD_MASK 8'h7f
`define SLFA_CMD_LOCKWR 8'h09
`define SLFA_CMD_LOCKRD 8'h09
`define SLFA_CMD_SIGNATURE_READ_SELECT 8'h21
// Pointer addresses
`define SLFA_PTR_FUSE_LO 16'h0000
`define SLFA_PTR_LOCK 16'h0001
`define SLFA_PTR_FUSE_EXT 16'h0002
`define SLFA_PTR_FUSE_HI 16'h0003
`define SLFA_PTR_SIG1 16'h0000
`define SLFA_PTR_CAL 16'h0001
`define SLFA_PTR_SIG2 16'h0002
`define SLFA_PTR_SIG3 16'h0004
`define SLFA_PTR_RECOMMENDED 16'h0001
// Windows in cycles
`define SLFA_STORE_WINDOW 4
`define SLFA_LOAD_WINDOW 3
// Reset values: all unprogrammed
`define SLFA_LOCK_RESET 8'hff
`define SLFA_FUSE_RESET 8'hff
`define SLFA_LOCK_UNUSED 8'hc0
// Lock write time in ns and clock period
`define SLFA_CLK_PERIOD_NS 4
`define SLFA_WRITE_MIN_NS 3700000
`define SLFA_WRITE_MAX_NS 4500000
`define SLFA_WRITE_CYCLES ((`SLFA_WRITE_MIN_NS + `SLFA_CLK_PERIOD_NS - 1) / `SLFA_CLK_PERIOD_NS)

`endif

/* File: common/slfa_pkg.sv */
// Types shared by both ends of the special-access link.
// Assumes slfa_defs.svh supplies the numeric constants.
package slfa_pkg;
    typedef enum logic [1:0] {SLFA_OP_NONE, SLFA_OP_LOCKWR, SLFA_OP_LOCKRD, SLFA_OP_SIGNATURE_READ_SELECT} slfa_op_t;
    typedef logic [7:0] slfa_byte_t;
    typedef logic [15:0] slfa_ptr_t;
endpackage

/* File: common/slfa_if.sv */
// Link between the processor core and the special-access logic.
// Assumes both ends run on the same clock; the bench joins them.
`timescale 1ns/10ps
`default_nettype none
interface slfa_if;
    logic ctrlWrite;
    logic [7:0] ctrlData;
    logic [7:0] ctrlStatus;
    logic storeStrobe;
    logic loadStrobe;
    logic [15:0] pointer;
    logic [7:0] lowData;
    logic [7:0] loadData;
    logic loadValid;
    logic flashRead;
    logic [7:0] flashByte;

    // Core side
    modport core (output ctrlWrite, output ctrlData, input ctrlStatus, output storeStrobe, output loadStrobe,
                  output pointer, output lowData, input loadData, input loadValid);
    // Access logic side
    modport dev (input ctrlWrite, input ctrlData, output ctrlStatus, input storeStrobe, input loadStrobe,
                 input pointer, input lowData, output loadData, output loadValid, output flashRead,
                 input flashByte);
endinterface
`default_nettype wire

/* File: design/slfa_core_end.sv */
// Core end: turns user requests into timed control write plus instruction; a plain load gets the instruction only.
// Assumes one request at a time; the caller waits for reqDone.
`timescale 1ns/10ps
`default_nettype none
module slfa_core_end
    import slfa_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    slfa_if.core link,
    input wire logic reqValid,
    input wire slfa_op_t reqOp,
    input wire logic [15:0] reqPtr,
    input wire logic [7:0] reqData,
    input wire logic eepromWriteBusy,
    output logic reqReady,
    output logic reqDone,
    output logic [7:0] rspData,
    output logic reqRefused
);
`include "slfa_defs.svh"
    typedef enum logic [2:0] {SLFA_C_IDLE, SLFA_C_POLL, SLFA_C_CTRL, SLFA_C_INSTR, SLFA_C_WAIT} slfa_cst_t;
    slfa_cst_t state_q;
    slfa_op_t op_q;
    logic [15:0] ptr_q;
    logic [7:0] data_q;
    logic ctrlWrite_q, store_q, load_q, done_q, refused_q;
    logic [7:0] rsp_q;
    logic [7:0] cmd;

    // Command code per operation; pointer ignored for lock write
    assign cmd = (op_q == SLFA_OP_SIGNATURE_READ_SELECT) ? `SLFA_CMD_SIGNATURE_READ_SELECT : `SLFA_CMD_LOCKWR;
    assign link.ctrlWrite = ctrlWrite_q;
    assign link.ctrlData = cmd;
    assign link.storeStrobe = store_q;
    assign link.loadStrobe = load_q;
    assign link.pointer = (op_q == SLFA_OP_LOCKWR) ? `SLFA_PTR_RECOMMENDED : ptr_q;
    assign link.lowData = data_q | `SLFA_LOCK_UNUSED;
    assign reqReady = (state_q == SLFA_C_IDLE);
    assign reqDone = done_q;
    assign rspData = rsp_q;
    assign reqRefused = refused_q;

    // Sequencer: wait idle device, write control, issue instruction next cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= SLFA_C_IDLE;
            op_q <= SLFA_OP_NONE;
            ptr_q <= 16'h0000;
            data_q <= 8'h00;
            ctrlWrite_q <= 1'b0;
            store_q <= 1'b0;
            load_q <= 1'b0;
            done_q <= 1'b0;
            refused_q <= 1'b0;
            rsp_q <= 8'h00;
        end else begin
            ctrlWrite_q <= 1'b0;
            store_q <= 1'b0;
            load_q <= 1'b0;
            done_q <= 1'b0;
            refused_q <= 1'b0;
            unique case (state_q)
                SLFA_C_IDLE: begin
                    if (reqValid) begin
                        op_q <= reqOp;
                        ptr_q <= reqPtr;
                        data_q <= reqData;
                        state_q <= SLFA_C_POLL;
                    end
                end
                SLFA_C_POLL: begin
                    // Previous write finished and no EEPROM write
                    if (!eepromWriteBusy && !link.ctrlStatus[`SLFA_BIT_ENABLE]) begin
                        // A plain load skips the control write
                        ctrlWrite_q <= (op_q != SLFA_OP_NONE);
                        state_q <= SLFA_C_CTRL;
                    end
                end
                SLFA_C_CTRL: begin
                    store_q <= (op_q == SLFA_OP_LOCKWR);
                    load_q <= (op_q != SLFA_OP_LOCKWR);
                    state_q <= SLFA_C_INSTR;
                end
                SLFA_C_INSTR: begin
                    state_q <= SLFA_C_WAIT;
                end
                SLFA_C_WAIT: begin
                    if (op_q == SLFA_OP_LOCKWR) begin
                        if (!link.ctrlStatus[`SLFA_BIT_ENABLE]) begin
                            done_q <= 1'b1;
                            refused_q <= 1'b0;
                            state_q <= SLFA_C_IDLE;
                        end
                    end else begin
                        done_q <= 1'b1;
                        rsp_q <= link.loadData;
                        refused_q <= !link.loadValid;
                        state_q <= SLFA_C_IDLE;
                    end
                end
                default: state_q <= SLFA_C_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: design/slfa_access.sv */
// Device end: control register, timed windows, lock write timer, byte reads.
// Assumes the core end drives the link on the same clock; flash array external.
`timescale 1ns/10ps
`default_nettype none
`include "slfa_defs.svh"
module slfa_access
    import slfa_pkg::*;
#(
    parameter int WRITE_CYCLES = `SLFA_WRITE_CYCLES,
    parameter logic [7:0] SIG_BYTE1 = 8'h5a, // Arbitrary identity value
    parameter logic [7:0] SIG_BYTE2 = 8'h3c, // Arbitrary identity value
    parameter logic [7:0] SIG_BYTE3 = 8'h11, // Arbitrary identity value
    parameter logic [7:0] CAL_BYTE = 8'h80,
    parameter logic [7:0] FUSE_LO_INIT = `SLFA_FUSE_RESET,
    parameter logic [7:0] FUSE_HI_INIT = `SLFA_FUSE_RESET,
    parameter logic [7:0] FUSE_EXT_INIT = `SLFA_FUSE_RESET
)(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic por_b,
    slfa_if.dev link,
    input wire logic eepromWriteBusy,
    output logic selfprogIrq,
    output logic [7:0] lockBits,
    output logic writeBusy
);
    initial begin
        if (WRITE_CYCLES < 1 || WRITE_CYCLES > 2097151) $error("WRITE_CYCLES out of range");
    end

    logic [7:0] ctrl_q;
    logic [2:0] win_q;
    logic [20:0] timer_q;
    logic [7:0] lock_q, pend_q;
    logic wrBusy_q;
    logic [7:0] loadData_q;
    logic loadValid_q;
    logic irq_q;
    logic lockArmed, sigArmed, cmdLock, cmdSig, lockHit, loadHit, expired, timerDone;
    logic [7:0] fuseByte, sigByte, specialByte;

    // Decode armed commands; a busy write holds off new commands
    assign cmdLock = ((link.ctrlData & `SLFA_CMD_MASK) == `SLFA_CMD_LOCKWR);
    assign cmdSig = ((link.ctrlData & `SLFA_CMD_MASK) == `SLFA_CMD_SIGNATURE_READ_SELECT);
    assign lockArmed = ctrl_q[`SLFA_BIT_LOCKSEL] && ctrl_q[`SLFA_BIT_ENABLE] && !wrBusy_q;
    assign sigArmed = ctrl_q[`SLFA_BIT_SIGSEL] && ctrl_q[`SLFA_BIT_ENABLE];
    assign lockHit = lockArmed && link.storeStrobe && win_q < 3'(`SLFA_STORE_WINDOW) && !eepromWriteBusy;
    assign loadHit = (lockArmed || sigArmed) && link.loadStrobe && win_q < 3'(`SLFA_LOAD_WINDOW);
    assign expired = (lockArmed && win_q >= 3'(`SLFA_STORE_WINDOW - 1)) ||
                     (sigArmed && win_q >= 3'(`SLFA_LOAD_WINDOW - 1));
    assign timerDone = wrBusy_q && (timer_q == 21'd1);

    // Byte selection; fuses and locks read zero when programmed
    assign fuseByte = (link.pointer == `SLFA_PTR_FUSE_LO) ? FUSE_LO_INIT :
                      (link.pointer == `SLFA_PTR_LOCK) ? (lock_q | `SLFA_LOCK_UNUSED) :
                      (link.pointer == `SLFA_PTR_FUSE_EXT) ? FUSE_EXT_INIT :
                      (link.pointer == `SLFA_PTR_FUSE_HI) ? FUSE_HI_INIT : 8'hff;
    assign sigByte = (link.pointer == `SLFA_PTR_SIG1) ? SIG_BYTE1 :
                     (link.pointer == `SLFA_PTR_CAL) ? CAL_BYTE :
                     (link.pointer == `SLFA_PTR_SIG2) ? SIG_BYTE2 :
                     (link.pointer == `SLFA_PTR_SIG3) ? SIG_BYTE3 : 8'h00;
    assign specialByte = sigArmed ? sigByte : fuseByte;

    assign link.ctrlStatus = ctrl_q;
    assign link.loadData = loadData_q;
    assign link.loadValid = loadValid_q;
    assign link.flashRead = 1'b1;
    assign selfprogIrq = irq_q;
    assign lockBits = lock_q;
    assign writeBusy = wrBusy_q;

    // Control register, window counter and auto-clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= 8'h00;
            win_q <= 3'd0;
        end else if (link.ctrlWrite && !wrBusy_q && !(eepromWriteBusy && (cmdLock || cmdSig))) begin
            ctrl_q <= {link.ctrlData[`SLFA_BIT_IRQEN], 1'b0, link.ctrlData[5:0]};
            win_q <= 3'd0;
        end else if (lockHit) begin
            ctrl_q <= (ctrl_q & ~8'h08) | 8'h41;
        end else if (timerDone) begin
            ctrl_q <= ctrl_q & 8'h80;
        end else if (loadHit || expired) begin
            ctrl_q <= ctrl_q & 8'h80;
        end else if (ctrl_q[`SLFA_BIT_ENABLE] && !wrBusy_q) begin
            win_q <= win_q + 3'd1;
        end
    end

    // Lock write timer survives system reset; only power-on clears it
    always_ff @(posedge clk or negedge por_b) begin
        if (!por_b) begin
            wrBusy_q <= 1'b0;
            timer_q <= 21'd0;
            pend_q <= `SLFA_LOCK_RESET;
            lock_q <= `SLFA_LOCK_RESET;
        end else if (lockHit) begin
            wrBusy_q <= 1'b1;
            timer_q <= 21'(WRITE_CYCLES);
            pend_q <= link.lowData | `SLFA_LOCK_UNUSED;
        end else if (timerDone) begin
            wrBusy_q <= 1'b0;
            lock_q <= lock_q & pend_q;
        end else if (wrBusy_q) begin
            timer_q <= timer_q - 21'd1;
        end
    end

    // Load answer: special byte while armed and within the load window, flash byte otherwise
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            loadData_q <= 8'h00;
            loadValid_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            loadValid_q <= link.loadStrobe && !(lockArmed && eepromWriteBusy && loadHit);
            if (link.loadStrobe) begin
                loadData_q <= loadHit ? specialByte : link.flashByte;
            end
            irq_q <= ctrl_q[`SLFA_BIT_IRQEN] && !ctrl_q[`SLFA_BIT_ENABLE];
        end
    end
endmodule
`default_nettype wire

/* File: tb/slfa_props.sv */
// Checker for the special-access link between the core end and the access logic.
// Assumes the bench wires it beside the link and hands on the write length.
`timescale 1ns/10ps
`default_nettype none
module slfa_props #(
    parameter int WRITE_CYCLES = 20
)(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ctrlWrite,
    input wire logic [7:0] ctrlData,
    input wire logic [7:0] ctrlStatus,
    input wire logic loadStrobe,
    input wire logic [7:0] loadData,
    input wire logic loadValid,
    input wire logic flashRead,
    input wire logic [7:0] flashByte,
    input wire logic eepromWriteBusy
);
    localparam int RUN_LO = WRITE_CYCLES - 3;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // Lock write starts from a set enable bit, runs its timed span, then ends
    sequence s_write_start;
        $rose(ctrlStatus[6]) && $past(ctrlStatus[0]);
    endsequence
    sequence s_write_run;
        ##RUN_LO ctrlStatus[6] ##[1:8] !ctrlStatus[6];
    endsequence

    a_write_time: assert property (s_write_start |-> s_write_run) else $error("lock write time off");
    a_busy_enable: assert property (ctrlStatus[6] |-> ctrlStatus[0]) else $error("enable dropped in write");
    a_lock_window: assert property ($rose(ctrlStatus[3]) |-> ##[1:4] (!ctrlStatus[3] || ctrlStatus[6]))
        else $error("lock select not cleared");
    a_sig_window: assert property ($rose(ctrlStatus[5]) |-> ##[1:3] !ctrlStatus[5]) else $error("sig select stuck");
    a_load_cause: assert property (loadValid |-> $past(loadStrobe)) else $error("answer without load");
    a_plain_load: assert property (loadStrobe && !ctrlStatus[0] |=> loadValid && loadData == $past(flashByte))
        else $error("plain load wrong");
    a_ee_block: assert property (ctrlWrite && eepromWriteBusy && (ctrlData[3] || ctrlData[5]) && !ctrlStatus[0]
        |=> !ctrlStatus[0]) else $error("command taken while eeprom busy");
    a_flash_read: assert property (flashRead) else $error("flash not readable");
endmodule
`default_nettype wire

/* File: tb/slfa_tb.sv */
// Bench for the core end and the access logic joined by one link.
// Assumes design files, package, link and checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin cmpCount++; if ((a) !== (b)) begin errors++; \
    $display("[FAIL] %0t got %h expected %h", $time, a, b); end end
module slfa_tb;
    import slfa_pkg::*;
    localparam int WC = 20;
    localparam logic [7:0] SIG1 = 8'h5a; // Arbitrary value
    localparam logic [7:0] SIG2 = 8'h3c; // Arbitrary value
    localparam logic [7:0] SIG3 = 8'h11; // Arbitrary value
    localparam logic [7:0] CAL = 8'h80;
    localparam logic [7:0] FLO = 8'ha5;
    localparam logic [7:0] FHI = 8'hd9;
    localparam logic [7:0] FEXT = 8'hfc;
    localparam logic [7:0] FLASH = 8'h6e;
    typedef struct {slfa_op_t op; logic [15:0] ptr; logic [7:0] exp;} slfa_row_t;
    logic clk, rst_b, por_b, eeCore, eeDev, reqValid, reqReady, reqDone, reqRefused, writeBusy;
    slfa_op_t reqOp;
    logic [15:0] reqPtr;
    logic [7:0] reqData, rspData, lockBits, rsp;
    logic irq;
    int errors = 0;
    int cmpCount = 0;
    slfa_row_t rows[9] = '{'{SLFA_OP_SIGNATURE_READ_SELECT, 16'h0000, SIG1}, '{SLFA_OP_SIGNATURE_READ_SELECT, 16'h0001, CAL},
        '{SLFA_OP_SIGNATURE_READ_SELECT, 16'h0002, SIG2}, '{SLFA_OP_SIGNATURE_READ_SELECT, 16'h0004, SIG3},
        '{SLFA_OP_LOCKRD, 16'h0000, FLO}, '{SLFA_OP_LOCKRD, 16'h0003, FHI},
        '{SLFA_OP_LOCKRD, 16'h0002, FEXT}, '{SLFA_OP_LOCKRD, 16'h0001, 8'hff},
        '{SLFA_OP_NONE, 16'h0040, FLASH}};

    slfa_if link();
    assign link.flashByte = FLASH;
    slfa_core_end slfa_core_end_inst(.clk, .rst_b, .link(link.core), .reqValid, .reqOp, .reqPtr, .reqData,
        .eepromWriteBusy(eeCore), .reqReady, .reqDone, .rspData, .reqRefused);
    slfa_access #(.WRITE_CYCLES(WC), .SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2), .SIG_BYTE3(SIG3), .CAL_BYTE(CAL),
        .FUSE_LO_INIT(FLO), .FUSE_HI_INIT(FHI), .FUSE_EXT_INIT(FEXT)) slfa_access_inst(.clk, .rst_b, .por_b,
        .link(link.dev), .eepromWriteBusy(eeDev), .selfprogIrq(irq), .lockBits, .writeBusy);
    slfa_props #(.WRITE_CYCLES(WC)) slfa_props_inst(.clk, .rst_b, .ctrlWrite(link.ctrlWrite),
        .ctrlData(link.ctrlData), .ctrlStatus(link.ctrlStatus), .loadStrobe(link.loadStrobe),
        .loadData(link.loadData), .loadValid(link.loadValid), .flashRead(link.flashRead),
        .flashByte(link.flashByte), .eepromWriteBusy(eeDev));

    // Clock at 250 MHz
    always #2 clk = ~clk;

    // Hands one request to the core end once it is ready
    task automatic issue(input slfa_op_t op, input logic [15:0] ptr, input logic [7:0] dat);
        int n;
        n = 0;
        while (reqReady !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        reqValid = 1'b1;
        reqOp = op;
        reqPtr = ptr;
        reqData = dat;
        @(posedge clk);
        #1;
        reqValid = 1'b0;
    endtask

    // Waits a bounded time for completion and keeps the answer
    task automatic do_req(input slfa_op_t op, input logic [15:0] ptr, input logic [7:0] dat);
        int n;
        issue(op, ptr, dat);
        n = 0;
        while (reqDone !== 1'b1 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        rsp = rspData;
        `CHK(reqDone, 1'b1)
    endtask

    task automatic finish_test;
        $display("Comparisons %0d mismatches %0d", cmpCount, errors);
        if (errors == 0 && cmpCount > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Reset, table of reads, then lock writes, a blocked write and a reset mid-write
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        por_b = 1'b0;
        eeCore = 1'b0;
        eeDev = 1'b0;
        reqValid = 1'b0;
        reqOp = SLFA_OP_NONE;
        reqPtr = 16'h0000;
        reqData = 8'h00;
        repeat (10) @(posedge clk);
        #1;
        rst_b = 1'b1;
        por_b = 1'b1;
        `CHK(link.ctrlStatus, 8'h00)
        `CHK(lockBits, 8'hff)
        `CHK(irq, 1'b0)
        foreach (rows[i]) begin
            do_req(rows[i].op, rows[i].ptr, 8'h00);
            `CHK(rsp, rows[i].exp)
            `CHK(link.ctrlStatus[0], 1'b0)
        end
        do_req(SLFA_OP_LOCKWR, 16'h0001, 8'hd6);
        `CHK(lockBits, 8'hd6)
        `CHK(writeBusy, 1'b0)
        do_req(SLFA_OP_LOCKRD, 16'h0001, 8'h00);
        `CHK(rsp, 8'hd6)
        eeDev = 1'b1;
        do_req(SLFA_OP_LOCKWR, 16'h0001, 8'hc0);
        `CHK(lockBits, 8'hd6)
        `CHK(writeBusy, 1'b0)
        eeDev = 1'b0;
        issue(SLFA_OP_LOCKWR, 16'h0001, 8'hfb);
        repeat (8) @(posedge clk);
        #1;
        `CHK(writeBusy, 1'b1)
        rst_b = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        rst_b = 1'b1;
        repeat (WC) @(posedge clk);
        #1;
        `CHK(lockBits, 8'hd2)
        do_req(SLFA_OP_LOCKRD, 16'h0001, 8'h00);
        `CHK(rsp, 8'hd2)
        finish_test();
    end

    // Cuts a hang short
    initial begin
        #20000;
        errors++;
        finish_test();
    end
endmodule
`default_nettype wire
